// ==== hsp_device.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hsp_regs.svh"

module hsp_device (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // cpu register port
    input wire logic [3:0] i_cpu_addr,
    input wire logic i_cpu_wr,
    input wire logic [7:0] i_cpu_wdata,
    input wire logic i_cpu_rd,
    output logic [7:0] o_cpu_rdata,
    // host port interrupt request
    output logic o_irq_req,
    output logic o_irq_high,
    // pins
    hsp_if.dev pins
);
    logic [2:0] e_dir_reg;
    logic host_sel_reg;
    logic in_full_reg;
    logic out_full_reg;
    logic overrun_reg;
    logic [2:0] e_latch_reg;
    logic [7:0] conv_reg;
    logic [7:0] d_latch_reg;
    logic [7:0] d_dir_reg;
    logic irq_flag_reg;
    logic irq_en_reg;
    logic irq_pri_reg;
    logic [2:0] strb_s1_reg;
    logic [2:0] strb_s2_reg;
    logic rd_prev_reg;
    logic wr_prev_reg;
    logic [7:0] rdata_reg;

    // register decode
    wire wr_dir = i_cpu_wr & (i_cpu_addr == `HSP_ADDR_E_DIR_STATUS);
    wire wr_elat = i_cpu_wr & ((i_cpu_addr == `HSP_ADDR_E_PIN)
                             | (i_cpu_addr == `HSP_ADDR_E_LATCH));
    wire wr_conv = i_cpu_wr & (i_cpu_addr == `HSP_ADDR_CONV_CTRL);
    wire wr_ddata = i_cpu_wr & (i_cpu_addr == `HSP_ADDR_D_DATA);
    wire wr_dlat = i_cpu_wr & ((i_cpu_addr == `HSP_ADDR_D_DATA)
                             | (i_cpu_addr == `HSP_ADDR_D_LATCH));
    wire wr_ddir = i_cpu_wr & (i_cpu_addr == `HSP_ADDR_D_DIR);
    wire wr_flag = i_cpu_wr & (i_cpu_addr == `HSP_ADDR_IRQ_FLAGS);
    wire wr_en = i_cpu_wr & (i_cpu_addr == `HSP_ADDR_IRQ_EN);
    wire wr_pri = i_cpu_wr & (i_cpu_addr == `HSP_ADDR_IRQ_PRI);
    wire rd_ddata = i_cpu_rd & (i_cpu_addr == `HSP_ADDR_D_DATA);

    // host strobe detection on the second synchroniser stage
    wire sel_low = ~strb_s2_reg[`HSP_PIN_CS];
    wire rd_act = host_sel_reg & sel_low & ~strb_s2_reg[`HSP_PIN_RD];
    wire wr_act = host_sel_reg & sel_low & ~strb_s2_reg[`HSP_PIN_WR];
    wire wr_start = wr_act & ~wr_prev_reg;
    wire wr_end = ~wr_act & wr_prev_reg;
    wire rd_end = ~rd_act & rd_prev_reg;

    // e pins digital only when the converter field says so
    wire e_digital = (conv_reg[2:0] == `HSP_CONV_DIGITAL);
    wire [2:0] e_pin_read;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_epin
            // direction controls the driver even in analog or host use
            assign pins.e_dev_oe_n[gi] = e_dir_reg[gi];
            assign pins.e_dev_out[gi] = e_latch_reg[gi];
            assign e_pin_read[gi] = e_digital & pins.e_level[gi];
        end
    endgenerate

    // d port: host mode drives the latch during a selected read
    assign pins.d_dev_out = d_latch_reg;
    assign pins.d_dev_oe_n = host_sel_reg ? {8{~rd_act}} : d_dir_reg;

    wire [7:0] dir_status = {in_full_reg, out_full_reg, overrun_reg, host_sel_reg,
                             1'b0, e_dir_reg};
    wire [7:0] d_read = host_sel_reg ? d_latch_reg : pins.d_level;
    wire [7:0] rd_map [0:15];
    assign rd_map[0] = dir_status;
    assign rd_map[1] = {5'h00, e_pin_read};
    assign rd_map[2] = {5'h00, e_latch_reg};
    assign rd_map[3] = conv_reg;
    assign rd_map[4] = d_read;
    assign rd_map[5] = d_latch_reg;
    assign rd_map[6] = d_dir_reg;
    assign rd_map[7] = {irq_flag_reg, 7'h00};
    assign rd_map[8] = {irq_en_reg, 7'h00};
    assign rd_map[9] = {irq_pri_reg, 7'h00};
    generate
        for (gi = 10; gi < 16; gi++) begin : g_unmapped
            assign rd_map[gi] = 8'h00;
        end
    endgenerate

    // status updates: a set wins over a clear in the same cycle
    wire in_full_next = (in_full_reg & ~rd_ddata) | wr_end;
    wire out_full_next = (out_full_reg & ~rd_end) | (wr_ddata & host_sel_reg);
    wire overrun_next = (wr_dir ? i_cpu_wdata[`HSP_BIT_INPUT_OVERRUN] : overrun_reg)
                      | (wr_end & in_full_reg);
    wire flag_next = (wr_flag ? i_cpu_wdata[`HSP_BIT_HOST_IRQ] : irq_flag_reg)
                   | wr_end | rd_end;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strb_s1_reg <= 3'h7;
            strb_s2_reg <= 3'h7;
            rd_prev_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
        end else begin
            strb_s1_reg <= pins.e_level;
            strb_s2_reg <= strb_s1_reg;
            rd_prev_reg <= rd_act;
            wr_prev_reg <= wr_act;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            e_dir_reg <= `HSP_RST_E_DIR;
            host_sel_reg <= 1'b0;
            in_full_reg <= 1'b0;
            out_full_reg <= 1'b0;
            overrun_reg <= 1'b0;
            conv_reg <= `HSP_RST_CONV;
            d_dir_reg <= `HSP_RST_D_DIR;
        end else begin
            in_full_reg <= in_full_next;
            out_full_reg <= out_full_next;
            overrun_reg <= overrun_next;
            if (wr_dir) begin
                e_dir_reg <= i_cpu_wdata[2:0];
                host_sel_reg <= i_cpu_wdata[`HSP_BIT_HOST_SEL];
            end
            if (wr_conv) begin
                conv_reg <= i_cpu_wdata & `HSP_CONV_MASK;
            end
            if (wr_ddir) begin
                d_dir_reg <= i_cpu_wdata;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            e_latch_reg <= 3'(`HSP_RST_LATCH);
            d_latch_reg <= `HSP_RST_LATCH;
            irq_flag_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            irq_pri_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            irq_flag_reg <= flag_next;
            if (wr_elat) begin
                e_latch_reg <= i_cpu_wdata[2:0];
            end
            if (wr_start) begin
                d_latch_reg <= pins.d_level;
            end else if (wr_dlat) begin
                d_latch_reg <= i_cpu_wdata;
            end
            if (wr_en) begin
                irq_en_reg <= i_cpu_wdata[`HSP_BIT_HOST_IRQ];
            end
            if (wr_pri) begin
                irq_pri_reg <= i_cpu_wdata[`HSP_BIT_HOST_IRQ];
            end
            if (i_cpu_rd) begin
                rdata_reg <= rd_map[i_cpu_addr];
            end
        end
    end

    assign o_cpu_rdata = rdata_reg;
    assign o_irq_req = irq_flag_reg & irq_en_reg;
    assign o_irq_high = irq_pri_reg;
endmodule : hsp_device

`default_nettype wire

// ==== hsp_regs.svh ====
`ifndef HSP_REGS_SVH
`define HSP_REGS_SVH

// register indices on the cpu register port
`define HSP_ADDR_E_DIR_STATUS 4'h0
`define HSP_ADDR_E_PIN 4'h1
`define HSP_ADDR_E_LATCH 4'h2
`define HSP_ADDR_CONV_CTRL 4'h3
`define HSP_ADDR_D_DATA 4'h4
`define HSP_ADDR_D_LATCH 4'h5
`define HSP_ADDR_D_DIR 4'h6
`define HSP_ADDR_IRQ_FLAGS 4'h7
`define HSP_ADDR_IRQ_EN 4'h8
`define HSP_ADDR_IRQ_PRI 4'h9

// direction/status register fields
`define HSP_BIT_INPUT_FULL 7
`define HSP_BIT_OUTPUT_FULL 6
`define HSP_BIT_INPUT_OVERRUN 5
`define HSP_BIT_HOST_SEL 4
// host port flag, enable and priority sit at this bit of their registers
`define HSP_BIT_HOST_IRQ 7

// e pin roles in host port mode
`define HSP_PIN_RD 0
`define HSP_PIN_WR 1
`define HSP_PIN_CS 2

// reset values
`define HSP_RST_E_DIR 3'h7
`define HSP_RST_CONV 8'h00
`define HSP_RST_D_DIR 8'hff
`define HSP_RST_LATCH 8'h00

// converter control: implemented bits, and the field value making e pins digital
`define HSP_CONV_MASK 8'hcf
`define HSP_CONV_DIGITAL 3'h7

// host strobe timing in clock cycles
`define HSP_STROBE_CYC 6
`define HSP_GAP_CYC 4

`endif

// ==== hsp_pkg.sv ====
package hsp_pkg;

    typedef enum logic [1:0] {
        HSP_IDLE = 2'b00,
        HSP_SETUP = 2'b01,
        HSP_STROBE = 2'b10,
        HSP_GAP = 2'b11
    } hsp_host_state_t;

    typedef logic [7:0] hsp_byte_t;

endpackage : hsp_pkg

// ==== hsp_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface hsp_if;
    // e port: device and host drives, resolved level
    logic [2:0] e_dev_out;
    logic [2:0] e_dev_oe_n;
    logic [2:0] e_host_out;
    logic [2:0] e_host_oe_n;
    logic [2:0] e_level;
    // d port
    logic [7:0] d_dev_out;
    logic [7:0] d_dev_oe_n;
    logic [7:0] d_host_out;
    logic d_host_oe_n;
    logic [7:0] d_level;

    // undriven lines read high as if pulled up
    assign e_level = (~e_dev_oe_n & e_dev_out) | (e_dev_oe_n & ~e_host_oe_n & e_host_out)
                   | (e_dev_oe_n & e_host_oe_n);
    assign d_level = (~d_dev_oe_n & d_dev_out)
                   | (d_dev_oe_n & {8{~d_host_oe_n}} & d_host_out)
                   | (d_dev_oe_n & {8{d_host_oe_n}});

    modport dev (
        output e_dev_out, e_dev_oe_n, d_dev_out, d_dev_oe_n,
        input e_level, d_level
    );
    modport host (
        output e_host_out, e_host_oe_n, d_host_out, d_host_oe_n,
        input e_level, d_level
    );
endinterface : hsp_if

`default_nettype wire

// ==== hsp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hsp_regs.svh"

module hsp_host #(
    parameter int STROBE_CYC = `HSP_STROBE_CYC,
    parameter int GAP_CYC = `HSP_GAP_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // user requests
    input wire logic i_start_wr,
    input wire logic i_start_rd,
    input wire logic [7:0] i_wdata,
    output logic o_ready,
    output logic [7:0] o_rdata,
    output logic o_rdata_valid,
    // link
    hsp_if.host pins
);
    hsp_pkg::hsp_host_state_t state_reg;
    hsp_pkg::hsp_host_state_t state_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic is_wr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic rvalid_reg;

    wire idle = (state_reg == hsp_pkg::HSP_IDLE);
    wire start = idle & (i_start_wr | i_start_rd);
    wire cnt_done = (cnt_reg == 8'h00);
    wire active = (state_reg == hsp_pkg::HSP_SETUP) | (state_reg == hsp_pkg::HSP_STROBE);
    wire strobe = (state_reg == hsp_pkg::HSP_STROBE);
    wire sample = strobe & cnt_done & ~is_wr_reg;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_done ? 8'h00 : cnt_reg - 8'h01;
        unique case (state_reg)
            hsp_pkg::HSP_IDLE: begin
                if (start) begin
                    state_next = hsp_pkg::HSP_SETUP;
                    cnt_next = 8'h00;
                end
            end
            hsp_pkg::HSP_SETUP: begin
                state_next = hsp_pkg::HSP_STROBE;
                cnt_next = 8'(STROBE_CYC - 1);
            end
            hsp_pkg::HSP_STROBE: begin
                if (cnt_done) begin
                    state_next = hsp_pkg::HSP_GAP;
                    cnt_next = 8'(GAP_CYC - 1);
                end
            end
            hsp_pkg::HSP_GAP: begin
                if (cnt_done) begin
                    state_next = hsp_pkg::HSP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= hsp_pkg::HSP_IDLE;
            cnt_reg <= 8'h00;
            is_wr_reg <= 1'b0;
            wdata_reg <= 8'h00;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            rvalid_reg <= sample;
            if (start) begin
                is_wr_reg <= i_start_wr;
                wdata_reg <= i_wdata;
            end
            if (sample) begin
                rdata_reg <= pins.d_level;
            end
        end
    end

    // chip select low from setup through the strobe; rd on pin 0, wr on pin 1
    assign pins.e_host_out[`HSP_PIN_CS] = ~active;
    assign pins.e_host_out[`HSP_PIN_RD] = ~(strobe & ~is_wr_reg);
    assign pins.e_host_out[`HSP_PIN_WR] = ~(strobe & is_wr_reg);
    assign pins.e_host_oe_n = 3'h0;
    assign pins.d_host_out = wdata_reg;
    assign pins.d_host_oe_n = ~(active & is_wr_reg);

    assign o_ready = idle;
    assign o_rdata = rdata_reg;
    assign o_rdata_valid = rvalid_reg;
endmodule : hsp_host

`default_nettype wire

// ==== hsp_tb_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

module hsp_tb_asserts (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // link signals
    input wire logic [2:0] e_host_out,
    input wire logic [2:0] e_level,
    input wire logic [7:0] d_dev_oe_n,
    input wire logic [7:0] d_dev_out,
    input wire logic d_host_oe_n
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_rd_held;
        !e_host_out[0] [*4];
    endsequence
    sequence s_wr_gap;
        e_host_out[1] [*3];
    endsequence

    property p_rd_sel;
        !e_host_out[0] |-> !e_host_out[2];
    endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("read strobe without select");
    property p_wr_sel;
        !e_host_out[1] |-> !e_host_out[2];
    endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("write strobe without select");
    property p_rd_width;
        $fell(e_host_out[0]) |-> s_rd_held;
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("read strobe too short");
    property p_wr_gap;
        $rose(e_host_out[1]) |-> s_wr_gap;
    endproperty
    a_wr_gap: assert property (p_wr_gap) else $error("write gap too short");
    // data bus driven only two cycles behind a selected read strobe
    property p_d_drive;
        d_dev_oe_n != 8'hff |-> $past(!e_level[0] && !e_level[2], 2);
    endproperty
    a_d_drive: assert property (p_d_drive) else $error("data driven outside read");
    property p_no_clash;
        d_dev_oe_n != 8'hff |-> d_host_oe_n;
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("data bus contention");
    property p_wr_data;
        !e_host_out[1] |-> !d_host_oe_n;
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write without data");
    property p_rd_stable;
        d_dev_oe_n == 8'h00 && $past(d_dev_oe_n) == 8'h00 |-> $stable(d_dev_out);
    endproperty
    a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
endmodule : hsp_tb_asserts

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic i_clk, i_rst_n, cpu_wr, cpu_rd, start_wr, start_rd, rdy, rd_vld, irq, irq_hi;
    logic [3:0] addr;
    logic [7:0] wdata, hwdata, rdata, hrdata;
    int err_count, checks_done;

    hsp_if hif();
    hsp_device hsp_device_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cpu_addr(addr),
        .i_cpu_wr(cpu_wr), .i_cpu_wdata(wdata), .i_cpu_rd(cpu_rd), .o_cpu_rdata(rdata),
        .o_irq_req(irq), .o_irq_high(irq_hi), .pins(hif.dev));
    hsp_host hsp_host_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start_wr(start_wr),
        .i_start_rd(start_rd), .i_wdata(hwdata), .o_ready(rdy), .o_rdata(hrdata),
        .o_rdata_valid(rd_vld), .pins(hif.host));
    hsp_tb_asserts hsp_tb_asserts_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .e_host_out(hif.e_host_out), .e_level(hif.e_level), .d_dev_oe_n(hif.d_dev_oe_n),
        .d_dev_out(hif.d_dev_out), .d_host_oe_n(hif.d_host_oe_n));

    task tick;
        @(posedge i_clk);
        #1;
    endtask : tick
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : cmp
    task cpu_w(input logic [3:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        cpu_wr = 1'b1;
        tick();
        cpu_wr = 1'b0;
        tick();
    endtask : cpu_w
    task cpu_chk(input logic [3:0] a, input logic [7:0] exp);
        addr = a;
        cpu_rd = 1'b1;
        tick();
        cpu_rd = 1'b0;
        cmp(rdata, exp);
        tick();
    endtask : cpu_chk
    // one host transfer, then wait for the host to go idle again
    task host_op(input logic wr, input logic [7:0] d);
        int n;
        int pulses;
        hwdata = d;
        start_wr = wr;
        start_rd = !wr;
        tick();
        start_wr = 1'b0;
        start_rd = 1'b0;
        n = 0;
        pulses = 0;
        while (rdy !== 1'b1 && n < 100) begin
            tick();
            n++;
            if (rd_vld === 1'b1) pulses++;
        end
        if (n >= 100) err_count++;
        cmp(8'(pulses), {7'h00, !wr});
        repeat (2) tick();
    endtask : host_op
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        err_count++;
        end_of_test();
    end
    initial begin
        {i_rst_n, cpu_wr, cpu_rd, start_wr, start_rd, addr, wdata, hwdata} = '0;
        repeat (8) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        cpu_chk(4'h0, 8'h07);
        cpu_chk(4'h1, 8'h00);
        cpu_chk(4'h6, 8'hff);
        cpu_chk(4'h7, 8'h00);
        cpu_chk(4'hf, 8'h00);
        $display("test reset done");
        // all e pins driven: read strobe and select go low while host mode is off
        cpu_w(4'h3, 8'h07);
        cpu_w(4'h2, 8'h02);
        cpu_w(4'h0, 8'h00);
        repeat (3) tick();
        cpu_chk(4'h1, 8'h02);
        cpu_chk(4'h0, 8'h00);
        cpu_w(4'h0, 8'h05);
        repeat (3) tick();
        cpu_chk(4'h1, 8'h07);
        cpu_chk(4'h2, 8'h02);
        cpu_w(4'h1, 8'h04);
        cpu_chk(4'h2, 8'h04);
        cpu_w(4'h0, 8'h07);
        cpu_w(4'h3, 8'h00);
        repeat (3) tick();
        cpu_chk(4'h1, 8'h00);
        $display("test gpio done");
        cpu_w(4'h3, 8'h07);
        cpu_w(4'h0, 8'h17);
        host_op(1'b1, 8'ha5);
        cpu_chk(4'h0, 8'h97);
        cpu_chk(4'h7, 8'h80);
        cpu_chk(4'h4, 8'ha5);
        cpu_chk(4'h5, 8'ha5);
        cpu_chk(4'h0, 8'h17);
        host_op(1'b1, 8'h3c);
        host_op(1'b1, 8'hc3);
        cpu_chk(4'h0, 8'hb7);
        cpu_chk(4'h4, 8'hc3);
        cpu_chk(4'h0, 8'h37);
        cpu_w(4'h0, 8'h17);
        cpu_chk(4'h0, 8'h17);
        cpu_w(4'h4, 8'h5a);
        cpu_chk(4'h0, 8'h57);
        host_op(1'b0, 8'h00);
        cmp(hrdata, 8'h5a);
        cpu_chk(4'h0, 8'h17);
        cpu_w(4'h8, 8'h80);
        cpu_w(4'h9, 8'h80);
        tick();
        cmp({7'h0, irq}, 8'h01);
        cmp({7'h0, irq_hi}, 8'h01);
        cpu_w(4'h7, 8'h00);
        tick();
        cmp({7'h0, irq}, 8'h00);
        $display("test host port done");
        end_of_test();
    end
endmodule : tb

`default_nettype wire
